/* File: hw/async_tx_defines.svh */
// Constants for the async transmit start-threshold and link enhancement block.
// Assumes inclusion by bare name from any file of the block.
`ifndef ASYNC_TX_DEFINES_SVH
`define ASYNC_TX_DEFINES_SVH

// Set and clear aliases of the link enhancement register (byte addresses)
`define LE_SET_ADDR 12'hA88
`define LE_CLR_ADDR 12'hA8C

// Register reset value and the bits software may alter
`define LE_RESET_VAL 32'h0000_1000
`define LE_WR_MASK 32'h0000_F586

// Field positions
`define LE_PIPE_DIS_BIT 15
`define LE_RSVD14_BIT 14
`define LE_THR_HI 13
`define LE_THR_LO 12
`define LE_MPEG_EN_BIT 10
`define LE_DV_EN_BIT 8
`define LE_PRIO_EN_BIT 7
`define LE_RSVD2_BIT 2
`define LE_ACCEL_EN_BIT 1

// Start-threshold codes
`define THR_CODE_2K 2'h0
`define THR_CODE_1P7K 2'h1
`define THR_CODE_1K 2'h2
`define THR_CODE_512 2'h3

// Start thresholds in bytes
`define THR_2K_BYTES 16'h0800
`define THR_1P7K_BYTES 16'h06CD
`define THR_1K_BYTES 16'h0400
`define THR_512_BYTES 16'h0200

// Bytes per FIFO word, as a shift
`define WORD_BYTES_SHIFT 2

// CIP format codes that get the timestamp enhancement
`define CIP_FMT_MPEG 6'h20
`define CIP_FMT_DV 6'h00

`endif

/* File: hw/async_tx_pkg.sv */
// Types shared by the async transmit start-threshold block.
// Assumes nothing of its surroundings.
package async_tx_pkg;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND,
    TX_DRAIN
  } tx_state_e;

endpackage : async_tx_pkg

/* File: hw/tx_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock, active-low async reset, DEPTH a power of two.
`timescale 1ns/1ps
module tx_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic push, pop;

  // Honest full and empty from the count
  assign in_ready_o = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign count_o = count_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and count next values
  always_comb begin
    wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage array, written on push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

endmodule : tx_fifo

/* File: hw/async_tx_threshold.sv */
// Async transmit start control with fill threshold, store-and-forward,
// underrun recovery, and the link enhancement set/clear register.
// Assumes host words arrive on the same clock, the PHY side takes words on
// its ready, and RSTN_I already merges the platform, global and power-on resets.
`timescale 1ns/1ps
`include "async_tx_defines.svh"

module async_tx_threshold #(
  parameter int DEPTH = 8,
  parameter int RETRY_W = 4
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register access
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Retry count from the retries register
  input wire logic [RETRY_W-1:0] RETRY_LIMIT_I,
  // Packet words from host memory
  input wire logic [31:0] HOST_DATA_I,
  input wire logic HOST_EOP_I,
  input wire logic HOST_VALID_I,
  output logic HOST_READY_O,
  // Packet words toward the PHY
  output logic [31:0] TX_DATA_O,
  output logic TX_EOP_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output logic TX_UNDERRUN_O,
  // Isochronous stream format and enhancement controls
  input wire logic [5:0] CIP_FORMAT_CODE_I,
  output logic STAMP_FIX_O,
  output logic PRIORITY_ARB_EN_O,
  output logic ACCEL_NOTIFY_O,
  output logic PIPELINE_DIS_O
);
  localparam int CW = $clog2(DEPTH+1);

  async_tx_pkg::tx_state_e state_reg, state_next;
  logic [31:0] le_reg, le_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic retry_sf_reg, retry_sf_next;
  logic underrun_reg, underrun_next;
  logic [CW-1:0] eop_cnt_reg, eop_cnt_next;
  logic stamp_reg, stamp_next;
  logic prio_reg, prio_next;
  logic accel_reg, accel_next;
  logic pipe_reg, pipe_next;

  logic fifo_out_valid, fifo_out_ready;
  logic [32:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic push, pop, pop_eop;
  logic store_fwd;
  logic [15:0] thresh_bytes;
  logic [15:0] fifo_bytes;
  logic start_ok;

  // Word FIFO between host and PHY; its ready stalls the host
  tx_fifo #(
    .WIDTH(33),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(HOST_VALID_I),
    .in_ready_o(HOST_READY_O),
    .in_data_i({HOST_EOP_I, HOST_DATA_I}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .count_o(fifo_count)
  );

  // Handshake terms on both FIFO sides
  assign push = HOST_VALID_I & HOST_READY_O;
  assign pop = fifo_out_valid & fifo_out_ready;
  assign pop_eop = pop & fifo_out_data[32];

  // Threshold selection from the start-level code
  always_comb begin
    thresh_bytes = `THR_2K_BYTES;
    unique case (le_reg[`LE_THR_HI:`LE_THR_LO])
      `THR_CODE_2K: thresh_bytes = `THR_2K_BYTES;
      `THR_CODE_1P7K: thresh_bytes = `THR_1P7K_BYTES;
      `THR_CODE_1K: thresh_bytes = `THR_1K_BYTES;
      `THR_CODE_512: thresh_bytes = `THR_512_BYTES;
    endcase
  end

  // Store-and-forward when code is 2K, after an underrun, or no retries
  assign store_fwd = (le_reg[`LE_THR_HI:`LE_THR_LO] == `THR_CODE_2K)
                     | retry_sf_reg
                     | (RETRY_LIMIT_I == '0);

  // Bytes held in the whole FIFO across all packets, compared every cycle
  assign fifo_bytes = 16'(fifo_count) << `WORD_BYTES_SHIFT;
  assign start_ok = fifo_out_valid & ((eop_cnt_reg != '0)
                    | (!store_fwd & (fifo_bytes >= thresh_bytes)));

  // PHY-facing outputs; drain state discards without forwarding
  assign TX_DATA_O = fifo_out_data[31:0];
  assign TX_EOP_O = fifo_out_data[32];
  assign TX_VALID_O = (state_reg == async_tx_pkg::TX_SEND) & fifo_out_valid;
  assign fifo_out_ready = ((state_reg == async_tx_pkg::TX_SEND) & TX_READY_I)
                          | (state_reg == async_tx_pkg::TX_DRAIN);
  assign TX_UNDERRUN_O = underrun_reg;

  // Transmit sequencer, end-of-packet count and retry mode next values
  always_comb begin
    state_next = state_reg;
    retry_sf_next = retry_sf_reg;
    underrun_next = 1'b0;
    eop_cnt_next = eop_cnt_reg;
    if (push && HOST_EOP_I && !pop_eop) begin
      eop_cnt_next = CW'(eop_cnt_reg + 1'b1);
    end else if (pop_eop && !(push && HOST_EOP_I)) begin
      eop_cnt_next = CW'(eop_cnt_reg - 1'b1);
    end
    unique case (state_reg)
      async_tx_pkg::TX_IDLE: begin
        if (start_ok) begin
          state_next = async_tx_pkg::TX_SEND;
        end
      end
      async_tx_pkg::TX_SEND: begin
        if (!fifo_out_valid) begin
          // Packet is cut short; next try is store-and-forward
          state_next = async_tx_pkg::TX_DRAIN;
          underrun_next = 1'b1;
          retry_sf_next = 1'b1;
        end else if (pop_eop) begin
          state_next = async_tx_pkg::TX_IDLE;
          retry_sf_next = 1'b0;
        end
      end
      async_tx_pkg::TX_DRAIN: begin
        if (pop_eop) begin
          state_next = async_tx_pkg::TX_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= async_tx_pkg::TX_IDLE;
      retry_sf_reg <= 1'b0;
      underrun_reg <= 1'b0;
      eop_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      retry_sf_reg <= retry_sf_next;
      underrun_reg <= underrun_next;
      eop_cnt_reg <= eop_cnt_next;
    end
  end

  // Set/clear register writes and read-back next values
  always_comb begin
    le_next = le_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (REG_WR_I && (REG_ADDR_I == `LE_SET_ADDR)) begin
      le_next = le_reg | (REG_WDATA_I & `LE_WR_MASK);
    end else if (REG_WR_I && (REG_ADDR_I == `LE_CLR_ADDR)) begin
      le_next = le_reg & ~(REG_WDATA_I & `LE_WR_MASK);
    end
    if (REG_RD_I) begin
      rvalid_next = 1'b1;
      if ((REG_ADDR_I == `LE_SET_ADDR) || (REG_ADDR_I == `LE_CLR_ADDR)) begin
        rdata_next = le_reg & `LE_WR_MASK;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  // Enhancement outputs next values
  always_comb begin
    stamp_next = (le_reg[`LE_MPEG_EN_BIT] && (CIP_FORMAT_CODE_I == `CIP_FMT_MPEG))
                 || (le_reg[`LE_DV_EN_BIT] && (CIP_FORMAT_CODE_I == `CIP_FMT_DV));
    prio_next = le_reg[`LE_PRIO_EN_BIT];
    accel_next = le_reg[`LE_ACCEL_EN_BIT];
    pipe_next = le_reg[`LE_PIPE_DIS_BIT];
  end

  // Register file and enhancement output registers
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      le_reg <= `LE_RESET_VAL;
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      stamp_reg <= 1'b0;
      prio_reg <= 1'b0;
      accel_reg <= 1'b0;
      pipe_reg <= 1'b0;
    end else begin
      le_reg <= le_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      stamp_reg <= stamp_next;
      prio_reg <= prio_next;
      accel_reg <= accel_next;
      pipe_reg <= pipe_next;
    end
  end

  // Registered outputs
  assign REG_RDATA_O = rdata_reg;
  assign REG_RVALID_O = rvalid_reg;
  assign STAMP_FIX_O = stamp_reg;
  assign PRIORITY_ARB_EN_O = prio_reg;
  assign ACCEL_NOTIFY_O = accel_reg;
  assign PIPELINE_DIS_O = pipe_reg;

endmodule : async_tx_threshold

/* File: verification/async_tx_threshold_props.sv */
// Checker for the async transmit start block, top ports only.
// Assumes a bind from the testbench top.
`timescale 1ns/1ps
module async_tx_threshold_props (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register access
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  // Stream
  input wire logic HOST_EOP_I,
  input wire logic HOST_VALID_I,
  input wire logic HOST_READY_O,
  input wire logic [31:0] TX_DATA_O,
  input wire logic TX_EOP_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic TX_UNDERRUN_O,
  // Controls
  input wire logic [5:0] CIP_FORMAT_CODE_I,
  input wire logic STAMP_FIX_O,
  input wire logic PRIORITY_ARB_EN_O,
  input wire logic ACCEL_NOTIFY_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [7:0] pend_reg;
  logic [7:0] pend_next;
  // Whole packets stored but not yet sent
  always_comb begin
    pend_next = pend_reg + 8'(HOST_VALID_I & HOST_READY_O & HOST_EOP_I)
      - 8'(TX_VALID_O & TX_READY_I & TX_EOP_O);
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pend_reg <= 8'h00;
    end else begin
      pend_reg <= pend_next;
    end
  end
  sequence set7_s; REG_WR_I && REG_ADDR_I == 12'hA88 && REG_WDATA_I[7]; endsequence
  sequence clr1_s; REG_WR_I && REG_ADDR_I == 12'hA8C && REG_WDATA_I[1]; endsequence
  rvalid_follow_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered");
  rvalid_cause_a: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("answer without read");
  rsvd_zero_a: assert property (REG_RVALID_O |-> (REG_RDATA_O & 32'hFFFF_0A79) == 0)
    else $error("reserved bit set");
  prio_set_a: assert property (set7_s |-> ##[1:2] PRIORITY_ARB_EN_O)
    else $error("priority not on");
  accel_clr_a: assert property (clr1_s |-> ##[1:2] !ACCEL_NOTIFY_O)
    else $error("accel not off");
  stamp_fmt_a: assert property (STAMP_FIX_O |-> $past(CIP_FORMAT_CODE_I) inside {6'h20, 6'h00})
    else $error("stamp on wrong format");
  underrun_pulse_a: assert property (TX_UNDERRUN_O |-> !$past(TX_VALID_O) ##1 !TX_UNDERRUN_O)
    else $error("bad underrun pulse");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("word dropped");
  saf_start_a: assert property ($rose(TX_VALID_O) |-> pend_reg != 8'h00)
    else $error("start before packet end");
endmodule : async_tx_threshold_props

/* File: verification/phy_sink_model.sv */
// PHY side sink: takes words on valid and ready, can stall.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module phy_sink_model (
  // Clock and mode
  input wire logic clk_i,
  input wire logic stall_i,
  // Word stream
  input wire logic valid_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  logic [31:0] got[$];
  logic [1:0] phase = 2'h0;
  initial ready_o = 1'b0;
  // Slow mode takes one word in four cycles
  always @(negedge clk_i) begin
    phase <= phase + 2'h1;
    ready_o <= !stall_i || phase == 2'h3;
  end
  // Record accepted words
  always @(posedge clk_i) begin
    if (valid_i && ready_o) got.push_back(data_i);
  end
endmodule : phy_sink_model

/* File: verification/test_async_tx_threshold.sv */
// Testbench for the async transmit start block.
// Assumes the checker and sink model compiled before it.
`timescale 1ns/1ps
module test_async_tx_threshold;
  logic REF_CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic [11:0] REG_ADDR_I = 12'h000;
  logic REG_WR_I = 1'b0;
  logic REG_RD_I = 1'b0;
  logic [31:0] REG_WDATA_I = 32'h0000_0000;
  logic [31:0] REG_RDATA_O;
  logic REG_RVALID_O;
  logic [3:0] RETRY_LIMIT_I = 4'h0;
  logic [31:0] HOST_DATA_I = 32'h0000_0000;
  logic HOST_EOP_I = 1'b0;
  logic HOST_VALID_I = 1'b0;
  logic [5:0] CIP_FORMAT_CODE_I = 6'h01;
  logic [31:0] TX_DATA_O;
  logic HOST_READY_O, TX_EOP_O, TX_VALID_O, TX_READY_I, TX_UNDERRUN_O;
  logic STAMP_FIX_O, PRIORITY_ARB_EN_O, ACCEL_NOTIFY_O, PIPELINE_DIS_O;
  logic stall = 1'b1;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 REF_CLK_I = ~REF_CLK_I;
  async_tx_threshold dut (.REF_CLK_I, .RSTN_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I,
    .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .RETRY_LIMIT_I, .HOST_DATA_I, .HOST_EOP_I,
    .HOST_VALID_I, .HOST_READY_O, .TX_DATA_O, .TX_EOP_O, .TX_VALID_O, .TX_READY_I,
    .TX_UNDERRUN_O, .CIP_FORMAT_CODE_I, .STAMP_FIX_O, .PRIORITY_ARB_EN_O, .ACCEL_NOTIFY_O,
    .PIPELINE_DIS_O);
  phy_sink_model phy (.clk_i(REF_CLK_I), .stall_i(stall), .valid_i(TX_VALID_O),
    .data_i(TX_DATA_O), .ready_o(TX_READY_I));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Hang guard
  always @(posedge REF_CLK_I) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge REF_CLK_I);
    {REG_WR_I, REG_ADDR_I, REG_WDATA_I} = {1'b1, a, d};
    @(negedge REF_CLK_I);
    REG_WR_I = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge REF_CLK_I);
    {REG_RD_I, REG_ADDR_I} = {1'b1, a};
    @(negedge REF_CLK_I);
    REG_RD_I = 1'b0;
    compare(32'(REG_RVALID_O), 32'h0000_0001);
    compare(REG_RDATA_O, e);
  endtask : reg_rd
  task automatic fmt(input logic [5:0] f, input logic e);
    CIP_FORMAT_CODE_I = f;
    repeat (3) @(negedge REF_CLK_I);
    compare(32'(STAMP_FIX_O), 32'(e));
  endtask : fmt
  task automatic push(input logic [31:0] d, input logic e);
    {HOST_VALID_I, HOST_DATA_I, HOST_EOP_I} = {1'b1, d, e};
    while (HOST_READY_O !== 1'b1) @(negedge REF_CLK_I);
    @(negedge REF_CLK_I);
  endtask : push
  task automatic regs_test;
    reg_rd(12'hA88, 32'h0000_1000);
    reg_wr(12'hA88, 32'hFFFF_BFFB);
    reg_rd(12'hA88, 32'h0000_B582);
    compare(32'({PRIORITY_ARB_EN_O, ACCEL_NOTIFY_O}), 32'h0000_0003);
    fmt(6'h20, 1'b1);
    fmt(6'h00, 1'b1);
    fmt(6'h01, 1'b0);
    reg_wr(12'hA8C, 32'h0000_0400);
    fmt(6'h20, 1'b0);
    reg_wr(12'hA8C, 32'hFFFF_FFFF);
    reg_wr(12'hA90, 32'hFFFF_FFFF);
    reg_rd(12'hA88, 32'h0000_0000);
    reg_rd(12'hA90, 32'h0000_0000);
    compare(32'({PRIORITY_ARB_EN_O, ACCEL_NOTIFY_O}), 32'h0000_0000);
  endtask : regs_test
  task automatic pkt_test(input int n, input logic [31:0] base, input logic slow);
    stall = slow;
    @(negedge REF_CLK_I);
    for (int i = 0; i < n - 1; i++) push(base + 32'(i), 1'b0);
    HOST_VALID_I = 1'b0;
    repeat (4) @(negedge REF_CLK_I);
    compare(32'(TX_VALID_O), 32'h0000_0000);
    push(base + 32'(n - 1), 1'b1);
    HOST_VALID_I = 1'b0;
    if (n == 8) compare(32'(HOST_READY_O), 32'h0000_0000);
    for (int k = 0; k < 200 && phy.got.size() < n; k++) @(negedge REF_CLK_I);
    compare(32'(phy.got.size()), 32'(n));
    for (int i = 0; i < phy.got.size(); i++) compare(phy.got[i], base + 32'(i));
    phy.got.delete();
  endtask : pkt_test
  initial begin
    repeat (10) @(posedge REF_CLK_I);
    @(negedge REF_CLK_I);
    RSTN_I = 1'b1;
    regs_test();
    reg_wr(12'hA88, 32'h0000_3000);
    pkt_test(8, 32'h0000_0100, 1'b1);
    RETRY_LIMIT_I = 4'h3;
    pkt_test(3, 32'h0000_0200, 1'b0);
    reg_wr(12'hA8C, 32'h0000_3000);
    pkt_test(5, 32'h0000_0300, 1'b1);
    give_verdict();
  end
endmodule : test_async_tx_threshold
bind async_tx_threshold async_tx_threshold_props chk (.REF_CLK_I, .RSTN_I, .REG_ADDR_I,
  .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .HOST_EOP_I,
  .HOST_VALID_I, .HOST_READY_O, .TX_DATA_O, .TX_EOP_O, .TX_VALID_O, .TX_READY_I,
  .TX_UNDERRUN_O, .CIP_FORMAT_CODE_I, .STAMP_FIX_O, .PRIORITY_ARB_EN_O, .ACCEL_NOTIFY_O);
